// ---- common/synth_pkg.sv ----
package synth_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int N_W = 20;
  localparam int R_W = 13;
  localparam int AUX_OUT_W = 8;
  localparam int AUX_MAIN_W = 12;
  localparam int AUX_REF_W = 8;
  localparam int ADDR_W = 6;
  localparam int SYNC_W = 4;

  // ----------------------------------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [5:0] OFF_CTRL = 6'h00;
  localparam logic [5:0] OFF_DATA0 = 6'h04;
  localparam logic [5:0] OFF_DATA1 = 6'h08;
  localparam logic [5:0] OFF_DATA2 = 6'h0C;
  localparam logic [5:0] OFF_DATA3 = 6'h10;
  localparam logic [5:0] OFF_AUX_PLL1 = 6'h14;
  localparam logic [5:0] OFF_AUX_PLL2 = 6'h18;
  localparam logic [5:0] OFF_AUX_REF1 = 6'h1C;
  localparam logic [5:0] OFF_AUX_REF2 = 6'h20;
  localparam logic [5:0] OFF_STATUS = 6'h24;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CTRL_SEL1_BIT = 0;
  localparam int CTRL_GAIN1_BIT = 3;
  localparam int CTRL_SEL2_BIT = 8;
  localparam int CTRL_GAIN2_BIT = 11;
  localparam int D3_CH_BIT = 0;
  localparam int D3_SET_BIT = 1;
  localparam int AUX_MAIN_LSB = 8;
  localparam int AUX_BYPASS_BIT = 8;
  localparam logic [2:0] MASK_FULL = 3'h7;

  // ----------------------------------------------------------------
  // User configuration held in the firmware image (reset values)
  // ----------------------------------------------------------------
  localparam logic [1:0] IMG_SEL = 2'h0;
  localparam logic [1:0] IMG_GAIN = 2'h3;
  localparam logic [N_W-1:0] IMG_N = 20'h00BB8;
  localparam logic [R_W-1:0] IMG_R = 13'h0060;
  localparam logic [AUX_REF_W-1:0] IMG_AUX_REF = 8'hC8;
  localparam logic [AUX_MAIN_W-1:0] IMG_AUX_MAIN = 12'h190;
  localparam logic [AUX_OUT_W-1:0] IMG_AUX_OUT1 = 8'h04;
  localparam logic [AUX_OUT_W-1:0] IMG_AUX_OUT2 = 8'h02;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [N_W-1:0] n;
    logic [R_W-1:0] r;
  } divset_t;

  typedef struct packed {
    logic [AUX_OUT_W-1:0] out_div;
    logic [AUX_MAIN_W-1:0] main_div;
    logic [AUX_REF_W-1:0] ref_div;
    logic bypass;
  } aux_cfg_t;

  typedef struct packed {
    logic level;
    logic oe;
  } pump_t;

  typedef enum logic [0:0] {
    ST_LOAD = 1'b0,
    ST_RUN = 1'b1
  } load_state_t;

endpackage

// ---- rtl/count_divider.sv ----
`timescale 1ns/1ps
module count_divider #(
  parameter int W = 8
) (
  input wire logic clk, // Core clock
  input wire logic rst_n, // Async reset, active low
  input wire logic tick, // One-cycle count event
  input wire logic [W-1:0] div_value, // Divide ratio, 0 acts as 1
  output logic pulse, // One pulse per full count
  output logic square // Output clock, 1:1 for even ratios
);

  logic [W-1:0] cnt_reg;
  logic [W-1:0] cnt_next;
  logic [W-1:0] ratio;
  logic pulse_reg;
  logic square_reg;

  // ----------------------------------------------------------------
  // Next count; a new ratio is only picked up at terminal count
  // ----------------------------------------------------------------
  always_comb
  begin
    ratio = (div_value == '0) ? W'(1) : div_value;
    cnt_next = (cnt_reg == '0) ? ratio - W'(1) : cnt_reg - W'(1); // RQ20
  end

  // Counter, pulse and square output
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt_reg <= '0;
      pulse_reg <= 1'b0;
      square_reg <= 1'b0;
    end
    else
    begin
      pulse_reg <= tick && (cnt_reg == '0); // RQ20
      if (tick)
      begin
        cnt_reg <= cnt_next;
        square_reg <= cnt_next >= (ratio >> 1); // RQ16
      end
    end
  end

  assign pulse = pulse_reg;
  assign square = square_reg;

endmodule

// ---- rtl/phase_freq_detector.sv ----
`timescale 1ns/1ps
module phase_freq_detector (
  input wire logic clk, // Core clock
  input wire logic rst_n, // Async reset, active low
  input wire logic ref_pulse, // Divided reference
  input wire logic fb_pulse, // Divided feedback
  output synth_pkg::pump_t pump // Three-state pump drive
);

  logic up_reg;
  logic dn_reg;
  logic up_next;
  logic dn_next;
  synth_pkg::pump_t pump_reg;

  // Both flags high means phase matched: clear both, pump floats
  always_comb
  begin
    up_next = up_reg | ref_pulse;
    dn_next = dn_reg | fb_pulse;
    if (up_next && dn_next)
    begin
      up_next = 1'b0;
      dn_next = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Flags and high-impedance pump output
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      up_reg <= 1'b0;
      dn_reg <= 1'b0;
      pump_reg <= '0;
    end
    else
    begin
      up_reg <= up_next;
      dn_reg <= dn_next;
      pump_reg.level <= up_next; // RQ11
      pump_reg.oe <= up_next | dn_next; // RQ11
    end
  end

  assign pump = pump_reg;

endmodule

// ---- rtl/dual_synth_divider_config.sv ----
// Operation
// RQ1: Each RF channel holds two divider sets, each one N and one R.
// RQ2: N counter is 20 bits, R counter 13 bits, per channel.
// RQ3: R divides reference, N divides VCO, both to comparison rate.
// RQ4: A control register bit picks which set drives each channel.
// RQ5: Setup takes four data writes; registers may be partial until then.
// RQ6: Gain select bit is bit 3 for channel one, bit 11 for two.
// RQ7: Gain bit set selects four times the pump current.
// RQ8: Software keeps comparison frequency within 2.5kHz to 200kHz.
// RQ9: Both RF channels run from the one shared reference clock.
// RQ10: Writing one channel never changes the other channel's values.
// RQ11: Phase-frequency detector drives a high-impedance charge pump.
// RQ12: No lock status is produced for either RF channel.
// RQ13: RF reference comes from the internal clock path by default.
// RQ14: Two aux clock PLLs with output, main and reference dividers.
// RQ15: Software programs aux reference divider for 96kHz comparison.
// RQ16: Aux output divider gives equal high and low for even ratios.
// RQ17: Image defaults give aux outputs of 9.6MHz and 19.2MHz.
// RQ18: Divider settings load from the firmware image at start.
// RQ19: New divider values apply only after the fourth write. Aux divider values apply on their single register write.
// RQ20: Each divider pulses once per full count, then reloads.
`timescale 1ns/1ps
module dual_synth_divider_config (
  input wire logic clk, // Shared reference and core clock
  input wire logic rst_n, // Async reset, active low
  input wire logic [5:0] addr, // Register byte address
  input wire logic [31:0] wdata, // Write data
  input wire logic wr_en, // Write strobe
  input wire logic rd_en, // Read strobe
  output logic [31:0] rdata, // Read data, cycle after rd_en
  input wire logic image_reload, // Pulse: reload firmware_image setup
  input wire logic [1:0] rf_vco_in, // RF VCO feedback pins
  input wire logic [1:0] aux_vco_in, // Aux PLL VCO feedback pins
  output synth_pkg::pump_t [1:0] pump_output_pin, // RF charge pumps
  output logic [1:0] pump_gain_x4, // To pump_current_set_pin stage
  output synth_pkg::pump_t [1:0] aux_pump_pin, // Aux charge pumps
  output logic aux_clock_out_one, // Aux clock one
  output logic aux_clock_out_two, // Aux clock two
  output logic config_loading // High while image loads
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [3:0] sync1_reg;
  logic [3:0] sync2_reg;
  logic [3:0] sync3_reg;
  logic [3:0] vco_edge;
  synth_pkg::load_state_t state_reg;
  logic load_now;
  logic [1:0] sel_reg;
  logic [1:0] gain_reg;
  logic [synth_pkg::N_W-1:0] stage_n_reg;
  logic [synth_pkg::R_W-1:0] stage_r_reg;
  logic [2:0] mask_reg;
  synth_pkg::divset_t [1:0][1:0] set_reg;
  synth_pkg::aux_cfg_t [1:0] aux_reg;
  synth_pkg::divset_t [1:0] active;
  logic wr_d3;
  logic commit;
  logic [1:0] rf_ref_pulse;
  logic [1:0] rf_fb_pulse;
  logic [1:0] aux_ref_pulse;
  logic [1:0] aux_fb_pulse;
  logic [1:0] aux_ref_sq;
  logic [1:0] aux_out_sq;
  logic [1:0] aux_clk_reg;
  logic [31:0] rdata_reg;

  // Address match, shared by every write decode below
  function automatic logic hit(input logic [5:0] a,
                               input logic [5:0] off);
    hit = (a == off);
  endfunction

  // ----------------------------------------------------------------
  // VCO pin synchronisers; the second and third stages feed the edge test
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sync1_reg <= 4'h0;
      sync2_reg <= 4'h0;
      sync3_reg <= 4'h0;
    end
    else
    begin
      sync1_reg <= {aux_vco_in, rf_vco_in};
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
    end
  end

  assign vco_edge = sync2_reg & ~sync3_reg;

  // ----------------------------------------------------------------
  // Image load sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      state_reg <= synth_pkg::ST_LOAD;
    else
      case (state_reg)
        synth_pkg::ST_LOAD: state_reg <= synth_pkg::ST_RUN;
        synth_pkg::ST_RUN:
          if (image_reload)
            state_reg <= synth_pkg::ST_LOAD;
        default: state_reg <= synth_pkg::ST_LOAD;
      endcase
  end

  assign load_now = (state_reg == synth_pkg::ST_LOAD);
  assign config_loading = load_now;

  // Control register: set select and pump gain per channel
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sel_reg <= synth_pkg::IMG_SEL;
      gain_reg <= synth_pkg::IMG_GAIN;
    end
    else if (load_now)
    begin
      sel_reg <= synth_pkg::IMG_SEL; // RQ18
      gain_reg <= synth_pkg::IMG_GAIN; // RQ18
    end
    else if (wr_en && hit(addr, synth_pkg::OFF_CTRL))
    begin
      sel_reg[0] <= wdata[synth_pkg::CTRL_SEL1_BIT]; // RQ4
      sel_reg[1] <= wdata[synth_pkg::CTRL_SEL2_BIT]; // RQ4
      gain_reg[0] <= wdata[synth_pkg::CTRL_GAIN1_BIT]; // RQ6
      gain_reg[1] <= wdata[synth_pkg::CTRL_GAIN2_BIT]; // RQ6
    end
  end

  // High gain asks the pump stage for four times the current
  assign pump_gain_x4 = gain_reg; // RQ7

  // ----------------------------------------------------------------
  // Four-write setup: three staging writes, the fourth commits
  // ----------------------------------------------------------------
  assign wr_d3 = wr_en && hit(addr, synth_pkg::OFF_DATA3);
  assign commit = wr_d3 && (mask_reg == synth_pkg::MASK_FULL); // RQ5

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      stage_n_reg <= '0;
      stage_r_reg <= '0;
      mask_reg <= 3'h0;
    end
    else if (load_now || commit)
      mask_reg <= 3'h0; // RQ5
    else if (wr_en)
    begin
      if (hit(addr, synth_pkg::OFF_DATA0))
      begin
        stage_n_reg[15:0] <= wdata[15:0];
        mask_reg[0] <= 1'b1;
      end
      if (hit(addr, synth_pkg::OFF_DATA1))
      begin
        stage_n_reg[synth_pkg::N_W-1:16] <= wdata[3:0];
        mask_reg[1] <= 1'b1;
      end
      if (hit(addr, synth_pkg::OFF_DATA2))
      begin
        stage_r_reg <= wdata[synth_pkg::R_W-1:0];
        mask_reg[2] <= 1'b1;
      end
    end
  end

  // Divider sets; a commit touches only the addressed channel and set
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      set_reg <= {4{synth_pkg::IMG_N, synth_pkg::IMG_R}};
    else if (load_now)
      set_reg <= {4{synth_pkg::IMG_N, synth_pkg::IMG_R}}; // RQ18
    else if (commit) // RQ19
      set_reg[wdata[synth_pkg::D3_CH_BIT]][wdata[synth_pkg::D3_SET_BIT]]
        <= {stage_n_reg, stage_r_reg}; // RQ1 RQ10
  end

  // ----------------------------------------------------------------
  // Aux clock PLL configuration, two registers per output
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      aux_reg[0] <= {synth_pkg::IMG_AUX_OUT1, synth_pkg::IMG_AUX_MAIN,
                     synth_pkg::IMG_AUX_REF, 1'b0};
      aux_reg[1] <= {synth_pkg::IMG_AUX_OUT2, synth_pkg::IMG_AUX_MAIN,
                     synth_pkg::IMG_AUX_REF, 1'b0};
    end
    else if (load_now)
    begin
      aux_reg[0] <= {synth_pkg::IMG_AUX_OUT1, synth_pkg::IMG_AUX_MAIN,
                     synth_pkg::IMG_AUX_REF, 1'b0}; // RQ17
      aux_reg[1] <= {synth_pkg::IMG_AUX_OUT2, synth_pkg::IMG_AUX_MAIN,
                     synth_pkg::IMG_AUX_REF, 1'b0}; // RQ17
    end
    else if (wr_en)
      for (int i = 0; i < 2; i++)
      begin
        if (hit(addr, synth_pkg::OFF_AUX_PLL1 + 6'(4 * i)))
        begin
          aux_reg[i].out_div <= wdata[synth_pkg::AUX_OUT_W-1:0]; // RQ14
          aux_reg[i].main_div <= wdata[synth_pkg::AUX_MAIN_LSB +:
                                       synth_pkg::AUX_MAIN_W]; // RQ14
        end
        if (hit(addr, synth_pkg::OFF_AUX_REF1 + 6'(4 * i)))
        begin
          aux_reg[i].ref_div <= wdata[synth_pkg::AUX_REF_W-1:0]; // RQ14
          aux_reg[i].bypass <= wdata[synth_pkg::AUX_BYPASS_BIT]; // RQ14
        end
      end
  end

  // Set chosen by the control register drives each channel
  always_comb
  begin
    for (int i = 0; i < 2; i++)
      active[i] = set_reg[i][sel_reg[i]]; // RQ4
  end

  // ----------------------------------------------------------------
  // Divider chains; reference dividers tick on the shared clock
  // ----------------------------------------------------------------
  for (genvar g = 0; g < 2; g++)
  begin : gen_ch
    count_divider #(.W(synth_pkg::R_W)) u_rf_r ( // RQ2 RQ3 RQ9 RQ13
      .clk(clk),
      .rst_n(rst_n),
      .tick(1'b1),
      .div_value(active[g].r),
      .pulse(rf_ref_pulse[g]),
      .square()
    );
    count_divider #(.W(synth_pkg::N_W)) u_rf_n ( // RQ2 RQ3
      .clk(clk),
      .rst_n(rst_n),
      .tick(vco_edge[g]),
      .div_value(active[g].n),
      .pulse(rf_fb_pulse[g]),
      .square()
    );
    phase_freq_detector u_rf_pfd ( // RQ11
      .clk(clk),
      .rst_n(rst_n),
      .ref_pulse(rf_ref_pulse[g]),
      .fb_pulse(rf_fb_pulse[g]),
      .pump(pump_output_pin[g])
    );
    count_divider #(.W(synth_pkg::AUX_REF_W)) u_aux_r ( // RQ14
      .clk(clk),
      .rst_n(rst_n),
      .tick(1'b1),
      .div_value(aux_reg[g].ref_div),
      .pulse(aux_ref_pulse[g]),
      .square(aux_ref_sq[g])
    );
    count_divider #(.W(synth_pkg::AUX_MAIN_W)) u_aux_n ( // RQ14
      .clk(clk),
      .rst_n(rst_n),
      .tick(vco_edge[2 + g]),
      .div_value(aux_reg[g].main_div),
      .pulse(aux_fb_pulse[g]),
      .square()
    );
    phase_freq_detector u_aux_pfd (
      .clk(clk),
      .rst_n(rst_n),
      .ref_pulse(aux_ref_pulse[g]),
      .fb_pulse(aux_fb_pulse[g]),
      .pump(aux_pump_pin[g])
    );
    count_divider #(.W(synth_pkg::AUX_OUT_W)) u_aux_o ( // RQ16
      .clk(clk),
      .rst_n(rst_n),
      .tick(vco_edge[2 + g]),
      .div_value(aux_reg[g].out_div),
      .pulse(),
      .square(aux_out_sq[g])
    );
  end

  // Output routing: VCO output divider or divided reference
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      aux_clk_reg <= 2'h0;
    else
      for (int i = 0; i < 2; i++)
        aux_clk_reg[i] <= aux_reg[i].bypass ? aux_ref_sq[i]
                                            : aux_out_sq[i]; // RQ14
  end

  assign aux_clock_out_one = aux_clk_reg[0];
  assign aux_clock_out_two = aux_clk_reg[1];

  // ----------------------------------------------------------------
  // Read port; unmapped addresses read zero
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      rdata_reg <= 32'h0;
    else if (!rd_en)
      rdata_reg <= 32'h0;
    else
      case (addr)
        synth_pkg::OFF_CTRL:
          rdata_reg <= {20'h0, gain_reg[1], 2'h0, sel_reg[1],
                        4'h0, gain_reg[0], 2'h0, sel_reg[0]};
        synth_pkg::OFF_DATA0: rdata_reg <= {16'h0, stage_n_reg[15:0]};
        synth_pkg::OFF_DATA1: rdata_reg <= {28'h0, stage_n_reg[19:16]};
        synth_pkg::OFF_DATA2: rdata_reg <= {19'h0, stage_r_reg};
        synth_pkg::OFF_AUX_PLL1:
          rdata_reg <= {12'h0, aux_reg[0].main_div, aux_reg[0].out_div};
        synth_pkg::OFF_AUX_PLL2:
          rdata_reg <= {12'h0, aux_reg[1].main_div, aux_reg[1].out_div};
        synth_pkg::OFF_AUX_REF1:
          rdata_reg <= {23'h0, aux_reg[0].bypass, aux_reg[0].ref_div};
        synth_pkg::OFF_AUX_REF2:
          rdata_reg <= {23'h0, aux_reg[1].bypass, aux_reg[1].ref_div};
        // Staging progress and load state only; no lock bits exist
        synth_pkg::OFF_STATUS:
          rdata_reg <= {28'h0, load_now, mask_reg}; // RQ12
        default: rdata_reg <= 32'h0;
      endcase
  end

  assign rdata = rdata_reg;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  property p_gain_lo;
    wr_en && !load_now && hit(addr, synth_pkg::OFF_CTRL) |=>
      pump_gain_x4[0] == $past(wdata[3]);
  endproperty
  a_gain_lo: assert property (p_gain_lo) // RQ6
    else $error("gain bit 3 not applied");

  property p_gain_hi;
    wr_en && !load_now && hit(addr, synth_pkg::OFF_CTRL) |=>
      pump_gain_x4[1] == $past(wdata[11]);
  endproperty
  a_gain_hi: assert property (p_gain_hi) // RQ7
    else $error("gain bit 11 not applied");

  property p_partial;
    !load_now && !commit |=> $stable(set_reg);
  endproperty
  a_partial: assert property (p_partial) // RQ5
    else $error("divider set changed without full setup");

  property p_commit;
    commit && !load_now |=>
      set_reg[$past(wdata[0])][$past(wdata[1])] ==
      {$past(stage_n_reg), $past(stage_r_reg)} && mask_reg == 3'h0;
  endproperty
  a_commit: assert property (p_commit) // RQ1
    else $error("committed set does not hold staged values");

  property p_isolate;
    commit && !load_now && !wdata[0] |=> $stable(set_reg[1]);
  endproperty
  a_isolate: assert property (p_isolate) // RQ10
    else $error("other channel disturbed");

  property p_select;
    wr_en && !load_now && hit(addr, synth_pkg::OFF_CTRL) && wdata[0]
      |=> active[0] == set_reg[0][1];
  endproperty
  a_select: assert property (p_select) // RQ4
    else $error("selected set not driving channel one");

  property p_load;
    load_now |=> state_reg == synth_pkg::ST_RUN &&
      set_reg[1][1].n == synth_pkg::IMG_N;
  endproperty
  a_load: assert property (p_load) // RQ18
    else $error("image load did not complete");

  property p_default;
    load_now |=> aux_reg[0].out_div == 8'h04 &&
      aux_reg[1].out_div == 8'h02 && aux_reg[0].ref_div == 8'hC8;
  endproperty
  a_default: assert property (p_default) // RQ17
    else $error("aux defaults wrong after load");

  property p_pump;
    !pump_output_pin[0].oe && rf_ref_pulse[0] && !rf_fb_pulse[0] |=>
      pump_output_pin[0].oe && pump_output_pin[0].level;
  endproperty
  a_pump: assert property (p_pump) // RQ11
    else $error("pump did not source on leading reference");

  property p_refdiv;
    rf_ref_pulse[0] && active[0].r > 13'h0001 && $stable(active[0].r)
      |=> !rf_ref_pulse[0];
  endproperty
  a_refdiv: assert property (p_refdiv) // RQ20
    else $error("reference divider pulsed twice in a row");

  c_commit: cover property (commit);
  c_reload: cover property (image_reload ##1 load_now ##1 !load_now);
  c_aux_clk: cover property ($rose(aux_clock_out_one));
  c_pump: cover property (pump_output_pin[1].oe);

endmodule

// ---- tb/vco_model.sv ----
`timescale 1ns/1ps
// Behavioural VCO behind an integrating loop filter
module vco_model (
  input wire clk, // Core clock
  input wire synth_pkg::pump_t pump, // Charge pump drive
  output logic vco // VCO output to feedback pin
);
  int tune;
  int hp;
  // Source speeds up, sink slows down, float holds the tune
  always @(posedge clk)
  begin
    if (pump.oe === 1'b1)
    begin
      tune = (pump.level === 1'b1) ? tune - 4 : tune + 4;
    end
    tune = (tune < 6000) ? 6000 : ((tune > 40000) ? 40000 : tune);
    // Filter resistor: a pulse also kicks the phase, damping the loop
    hp = tune;
    if (pump.oe === 1'b1)
      hp = (pump.level === 1'b1) ? tune - 1600 : tune + 1600;
    // Clamp keeps the VCO slower than the pin synchroniser can see
    hp = (hp < 6000) ? 6000 : hp;
  end
  // Free running oscillator, half period in ps
  initial
  begin
    tune = 12000;
    hp = 12000;
    vco = 1'b0;
    forever
    begin
      #(hp / 1000.0);
      vco = ~vco;
    end
  end
endmodule

// ---- tb/dual_synth_divider_config_tb_top.sv ----
`timescale 1ns/1ps
module dual_synth_divider_config_tb_top;
  logic clk;
  logic rst_n;
  logic [5:0] addr;
  logic [31:0] wdata;
  logic wr_en;
  logic rd_en;
  logic [31:0] rdata;
  logic image_reload;
  wire [1:0] rf_vco_in;
  wire [1:0] aux_vco_in;
  synth_pkg::pump_t [1:0] pump_output_pin;
  logic [1:0] pump_gain_x4;
  synth_pkg::pump_t [1:0] aux_pump_pin;
  logic aux_clock_out_one;
  logic aux_clock_out_two;
  logic config_loading;
  int err_total;
  int checks_done;
  int hi;
  int lo;
  int cnt;
  real t0;
  real per;

  dual_synth_divider_config dut (
    .clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata),
    .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata),
    .image_reload(image_reload), .rf_vco_in(rf_vco_in),
    .aux_vco_in(aux_vco_in), .pump_output_pin(pump_output_pin),
    .pump_gain_x4(pump_gain_x4), .aux_pump_pin(aux_pump_pin),
    .aux_clock_out_one(aux_clock_out_one),
    .aux_clock_out_two(aux_clock_out_two),
    .config_loading(config_loading)
  );

  // One VCO per RF and per aux loop
  for (genvar i = 0; i < 2; i++)
  begin : g_vco
    vco_model rf (.clk(clk), .pump(pump_output_pin[i]),
      .vco(rf_vco_in[i]));
    vco_model ax (.clk(clk), .pump(aux_pump_pin[i]),
      .vco(aux_vco_in[i]));
  end

  // ----------------------------------------------------------------
  // Bus tasks and checking
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      err_total++;
      $display("CHECK FAILED t=%0t seen %h exp %h", $time, seen, exp);
    end
  endtask

  // Gap after each strobe so no signal is driven twice in a step
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
    @(posedge clk);
  endtask

  // Data stands in the next cycle only, zero after that
  task automatic rd(input logic [5:0] a, input logic [31:0] exp);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1 chk(rdata, exp);
    @(posedge clk);
    #1 chk(rdata, 32'h0);
    @(posedge clk);
  endtask

  task automatic summarize();
    if (err_total == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Stimulus
  // ----------------------------------------------------------------
  always #2 clk = ~clk;

  // Whole run is near 21k cycles, so 50k cycles means a hang
  initial
  begin
    #200000;
    err_total++;
    summarize();
  end

  initial
  begin
    clk = 1'b0;
    rst_n = 1'b0;
    addr = 6'h00;
    wdata = 32'h0;
    wr_en = 1'b0;
    rd_en = 1'b0;
    image_reload = 1'b0;
    err_total = 0;
    checks_done = 0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    rd(synth_pkg::OFF_CTRL, 32'h0000_0808);
    rd(synth_pkg::OFF_STATUS, 32'h0);
    // Partial setup: commit refused until all three data words land
    wr(synth_pkg::OFF_DATA0, 32'h0000_0018);
    wr(synth_pkg::OFF_DATA1, 32'h0);
    rd(synth_pkg::OFF_STATUS, 32'h3);
    wr(synth_pkg::OFF_DATA3, 32'h2);
    rd(synth_pkg::OFF_STATUS, 32'h3);
    wr(synth_pkg::OFF_DATA2, 32'h0000_0060);
    rd(synth_pkg::OFF_STATUS, 32'h7);
    wr(synth_pkg::OFF_DATA3, 32'h2);
    rd(synth_pkg::OFF_STATUS, 32'h0);
    // Channel one on set two with N 24, R 96: VCO at clk/4
    wr(synth_pkg::OFF_CTRL, 32'h0000_0009);
    #1 chk({30'h0, pump_gain_x4}, 32'h1);
    hi = 0;
    lo = 0;
    cnt = 0;
    repeat (20000)
    begin
      @(posedge clk);
      if (pump_output_pin[0].oe === 1'b1)
        hi++;
      else
        lo++;
      // Aux loop one sits far off lock, so its pump must source
      if (aux_pump_pin[0].oe === 1'b1 && aux_pump_pin[0].level === 1'b1)
        cnt++;
    end
    chk({31'h0, hi > 0 && lo > 0}, 32'h1);
    chk({31'h0, cnt > 0}, 32'h1);
    @(posedge rf_vco_in[0]);
    t0 = $realtime;
    repeat (64) @(posedge rf_vco_in[0]);
    per = ($realtime - t0) / 64.0;
    chk({31'h0, per > 12.0 && per < 20.0}, 32'h1);
    @(posedge clk);
    wr(synth_pkg::OFF_CTRL, 32'h0000_0800);
    #1 chk({30'h0, pump_gain_x4}, 32'h2);
    @(posedge clk);
    // Route divided reference out, even ratio on both aux clocks
    for (int i = 0; i < 2; i++)
    begin
      wr(synth_pkg::OFF_AUX_REF1 + 6'(4 * i), 32'h0000_0104);
      // Old ratio of up to 200 must run out before the new one loads
      repeat (260) @(posedge clk);
      hi = 0;
      lo = 0;
      repeat (64)
      begin
        @(posedge clk);
        if ((i == 0 ? aux_clock_out_one : aux_clock_out_two) === 1'b1)
          hi++;
        else
          lo++;
      end
      chk(hi, lo);
      chk({31'h0, hi > 0}, 32'h1);
    end
    // Unmapped place reads zero and swallows writes
    rd(6'h3C, 32'h0);
    wr(6'h3C, 32'hFFFF_FFFF);
    rd(synth_pkg::OFF_CTRL, 32'h0000_0800);
    // Image reload brings the defaults back
    image_reload <= 1'b1;
    @(posedge clk);
    image_reload <= 1'b0;
    cnt = 0;
    repeat (4)
    begin
      @(posedge clk);
      if (config_loading === 1'b1)
        cnt++;
    end
    chk(cnt, 1);
    rd(synth_pkg::OFF_CTRL, 32'h0000_0808);
    // Default ratio gives 96kHz comparison from a 19.2MHz reference
    rd(synth_pkg::OFF_AUX_REF1, 32'(synth_pkg::IMG_AUX_REF));
    rd(synth_pkg::OFF_AUX_PLL1,
       {12'h0, synth_pkg::IMG_AUX_MAIN, synth_pkg::IMG_AUX_OUT1});
    summarize();
  end
endmodule
